// [logic/nra_arbiter.sv]
// Reservation state and command decision logic for one namespace
`timescale 1ns/10ps
module nra_arbiter (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_CTRL_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic O_CMD_DONE,
  output logic [1:0] O_CMD_STATUS,
  output logic [nra_pkg::NRA_HOSTS-1:0] O_REL_NOTE,
  output logic [nra_pkg::NRA_HOSTS-1:0] O_PRE_NOTE,
  output logic [nra_pkg::NRA_HOSTS-1:0] O_ABORT_REQ
);
  import nra_pkg::*;

  typedef logic [NRA_HOSTS-1:0] nra_mask_t;

  logic [NRA_KEY_W-1:0] key_q [NRA_HOSTS];
  nra_mask_t regm_q, regm_d;
  logic resv_v_q, resv_v_d;
  logic [2:0] type_q, type_d;
  logic [NRA_HID_W-1:0] holder_q, holder_d;
  logic [NRA_KEY_W-1:0] current_key_field_q, preempt_key_field_q;
  logic [1:0] status_q, status_d;
  nra_mask_t rel_d, pre_d, abt_d;
  nra_mask_t note_rel_q, note_pre_q, note_abt_q;
  logic [31:0] prdata_q;

  // Holders under all-registrant types are every registrant
  function automatic logic all_reg(input logic [2:0] t);
    all_reg = (t == NRA_T_WE_AR) || (t == NRA_T_EA_AR);
  endfunction

  function automatic logic type_ok(input logic [2:0] t);
    type_ok = (t >= NRA_T_WE) && (t <= NRA_T_EA_AR);
  endfunction

  function automatic nra_mask_t key_hits(input logic [NRA_KEY_W-1:0] k,
                                         input nra_mask_t m);
    key_hits = '0;
    for (int i = 0; i < NRA_HOSTS; i++) begin
      key_hits[i] = m[i] && (key_q[i] == k);
    end
  endfunction

  // APB decode
  logic acc, wr, rd_setup, mapped, key_sel;
  logic [NRA_HID_W-1:0] key_idx;
  assign acc = I_PSEL && I_PENABLE;
  assign wr = acc && I_PWRITE;
  assign rd_setup = I_PSEL && !I_PENABLE && !I_PWRITE;
  assign key_sel = (I_PADDR[7:5] == NRA_OFF_KEY0[7:5]) &&
                   (I_PADDR[1:0] == 2'h0);
  assign key_idx = I_PADDR[4:2];
  assign mapped = key_sel || (I_PADDR == NRA_OFF_CMD) ||
                  (I_PADDR == NRA_OFF_CURRENT_KEY_FIELD) || (I_PADDR == NRA_OFF_PREEMPT_KEY_FIELD) ||
                  (I_PADDR == NRA_OFF_STATUS) || (I_PADDR == NRA_OFF_RESV) ||
                  (I_PADDR == NRA_OFF_NOTE);
  // Zero wait states: read data is captured in the setup phase
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = acc && !mapped;
  assign O_PRDATA = prdata_q;

  // Command word fields
  logic exec;
  logic [1:0] c_op;
  logic [2:0] c_act, c_type;
  logic c_ign;
  logic [NRA_HID_W-1:0] c_host;
  nra_mask_t hbit;
  assign exec = wr && (I_PADDR == NRA_OFF_CMD);
  assign c_op = I_PWDATA[NRA_CMD_OP_LSB +: 2];
  assign c_act = I_PWDATA[NRA_CMD_ACT_LSB +: 3];
  assign c_type = I_PWDATA[NRA_CMD_TYPE_LSB +: 3];
  assign c_ign = I_PWDATA[NRA_CMD_IGN_BIT];
  assign c_host = I_PWDATA[NRA_CMD_HID_LSB +: NRA_HID_W];
  assign hbit = nra_mask_t'(1) << c_host;

  logic is_reg, key_ok, is_holder;
  nra_mask_t hits;
  assign is_reg = regm_q[c_host];
  assign key_ok = c_ign || (key_q[c_host] == current_key_field_q);
  assign is_holder = resv_v_q &&
                     (all_reg(type_q) ? is_reg : (holder_q == c_host));
  // Process form so a key load alone also re-evaluates the match mask
  always_comb begin
    hits = key_hits(preempt_key_field_q, regm_q);
  end

  // Next state of one command, committed in one edge
  always_comb begin
    nra_mask_t rm;
    rm = '0;
    regm_d = regm_q;
    resv_v_d = resv_v_q;
    type_d = type_q;
    holder_d = holder_q;
    status_d = NRA_ST_OK;
    rel_d = '0;
    pre_d = '0;
    abt_d = '0;
    if (!is_reg || (!key_ok && c_op != NRA_OP_ACQUIRE)) begin
      status_d = NRA_ST_CONFLICT;
    end else if (c_op == NRA_OP_ACQUIRE && !key_ok) begin
      status_d = NRA_ST_CONFLICT;
    end else begin
      case (c_op)
        NRA_OP_REGISTER: begin
          if (c_act != NRA_REG_UNREGISTER) begin
            status_d = NRA_ST_INVALID;
          end else begin
            regm_d = regm_q & ~hbit;
            if (resv_v_q && (all_reg(type_q) ? ((regm_q & ~hbit) == '0)
                                           : (holder_q == c_host))) begin
              resv_v_d = 1'b0;
              if (type_q == NRA_T_WE_RO || type_q == NRA_T_EA_RO) begin
                rel_d = regm_q & ~hbit;
              end
            end
          end
        end
        NRA_OP_ACQUIRE: begin
          if (!type_ok(c_type)) begin
            status_d = NRA_ST_INVALID;
          end else if (c_act == NRA_ACQ_ACQUIRE) begin
            if (!resv_v_q) begin
              resv_v_d = 1'b1;
              type_d = c_type;
              holder_d = c_host;
            end else if (!is_holder || type_q != c_type) begin
              status_d = NRA_ST_CONFLICT;
            end
          end else if (c_act == NRA_ACQ_PREEMPT ||
                       c_act == NRA_ACQ_PREEMPT_ABORT) begin
            if (!resv_v_q) begin
              rm = hits;
            end else if (!all_reg(type_q)) begin
              if (preempt_key_field_q == key_q[holder_q]) begin
                rm = (holder_q == c_host) ? '0 : (nra_mask_t'(1) << holder_q);
                type_d = c_type;
                holder_d = c_host;
              end else if (preempt_key_field_q != '0) begin
                rm = hits;
              end else begin
                status_d = NRA_ST_INVALID;
              end
            end else if (preempt_key_field_q == '0) begin
              rm = regm_q & ~hbit;
              type_d = c_type;
              holder_d = c_host;
            end else if (hits == '0) begin
              status_d = NRA_ST_CONFLICT;
            end else begin
              rm = hits;
            end
            regm_d = regm_q & ~rm;
            pre_d = rm & ~hbit;
            if (c_act == NRA_ACQ_PREEMPT_ABORT) begin
              abt_d = rm & ~hbit;
            end
            if (resv_v_q && type_d != type_q) begin
              rel_d = regm_d & ~hbit;
            end
          end else begin
            status_d = NRA_ST_INVALID;
          end
        end
        NRA_OP_RELEASE: begin
          if (c_act != NRA_REL_RELEASE) begin
            status_d = NRA_ST_INVALID;
          end else if (!is_holder) begin
            status_d = NRA_ST_OK;
          end else if (c_type != type_q) begin
            status_d = NRA_ST_INVALID;
          end else begin
            resv_v_d = 1'b0;
            if (type_q != NRA_T_WE && type_q != NRA_T_EA) begin
              rel_d = regm_q & ~hbit;
            end
          end
        end
        default: begin
          status_d = NRA_ST_INVALID;
        end
      endcase
    end
  end

  // Reservation state: only the power-loss reset clears it
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      regm_q <= '0;
      resv_v_q <= 1'b0;
      type_q <= 3'h0;
      holder_q <= '0;
    end else if (exec) begin
      regm_q <= regm_d;
      resv_v_q <= resv_v_d;
      type_q <= type_d;
      holder_q <= holder_d;
    end else if (wr && key_sel) begin
      // Loading a key stands in for a register action
      regm_q <= regm_q | (nra_mask_t'(1) << key_idx);
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      for (int i = 0; i < NRA_HOSTS; i++) begin
        key_q[i] <= '0;
      end
    end else if (wr && key_sel) begin
      key_q[key_idx] <= I_PWDATA[NRA_KEY_W-1:0];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      current_key_field_q <= '0;
      preempt_key_field_q <= '0;
    end else if (wr && I_PADDR == NRA_OFF_CURRENT_KEY_FIELD) begin
      current_key_field_q <= I_PWDATA[NRA_KEY_W-1:0];
    end else if (wr && I_PADDR == NRA_OFF_PREEMPT_KEY_FIELD) begin
      preempt_key_field_q <= I_PWDATA[NRA_KEY_W-1:0];
    end
  end

  // Completion and event pulses
  always_ff @(posedge I_CLK) begin
    if (I_RST || I_CTRL_RST) begin
      status_q <= NRA_ST_OK;
      O_CMD_DONE <= 1'b0;
      O_REL_NOTE <= '0;
      O_PRE_NOTE <= '0;
      O_ABORT_REQ <= '0;
    end else begin
      O_CMD_DONE <= exec;
      O_REL_NOTE <= exec ? rel_d : '0;
      O_PRE_NOTE <= exec ? pre_d : '0;
      O_ABORT_REQ <= exec ? abt_d : '0;
      if (exec) begin
        status_q <= status_d;
      end
    end
  end
  assign O_CMD_STATUS = status_q;

  // Sticky notices, write one to clear; a new event wins over the clear
  logic note_wr;
  assign note_wr = wr && (I_PADDR == NRA_OFF_NOTE);
  always_ff @(posedge I_CLK) begin
    if (I_RST || I_CTRL_RST) begin
      note_rel_q <= '0;
      note_pre_q <= '0;
      note_abt_q <= '0;
    end else begin
      note_rel_q <= (note_rel_q & ~(note_wr ?
        I_PWDATA[NRA_NOTE_REL_LSB +: NRA_HOSTS] : '0)) | O_REL_NOTE;
      note_pre_q <= (note_pre_q & ~(note_wr ?
        I_PWDATA[NRA_NOTE_PRE_LSB +: NRA_HOSTS] : '0)) | O_PRE_NOTE;
      note_abt_q <= (note_abt_q & ~(note_wr ?
        I_PWDATA[NRA_NOTE_ABT_LSB +: NRA_HOSTS] : '0)) | O_ABORT_REQ;
    end
  end

  // Read data captured in setup phase
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      prdata_q <= NRA_RST_WORD;
    end else if (rd_setup) begin
      prdata_q <= NRA_RST_WORD;
      if (key_sel) begin
        prdata_q[NRA_KEY_W-1:0] <= key_q[key_idx];
      end else begin
        case (I_PADDR)
          NRA_OFF_CURRENT_KEY_FIELD: prdata_q[NRA_KEY_W-1:0] <= current_key_field_q;
          NRA_OFF_PREEMPT_KEY_FIELD: prdata_q[NRA_KEY_W-1:0] <= preempt_key_field_q;
          NRA_OFF_STATUS: prdata_q[1:0] <= status_q;
          NRA_OFF_RESV: begin
            prdata_q[NRA_RESV_VALID_BIT] <= resv_v_q;
            prdata_q[NRA_RESV_TYPE_LSB +: 3] <= type_q;
            prdata_q[NRA_RESV_HOLDER_LSB +: NRA_HID_W] <= holder_q;
            prdata_q[NRA_RESV_REGM_LSB +: NRA_HOSTS] <= regm_q;
          end
          NRA_OFF_NOTE: begin
            prdata_q[NRA_NOTE_REL_LSB +: NRA_HOSTS] <= note_rel_q;
            prdata_q[NRA_NOTE_PRE_LSB +: NRA_HOSTS] <= note_pre_q;
            prdata_q[NRA_NOTE_ABT_LSB +: NRA_HOSTS] <= note_abt_q;
          end
          default: prdata_q <= NRA_RST_WORD;
        endcase
      end
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  nonreg_conflict_a: assert property (
    exec && !is_reg |=> O_CMD_DONE && O_CMD_STATUS == NRA_ST_CONFLICT)
    else $error("non-registrant command not refused");
  unreg_drop_a: assert property (
    exec && c_op == NRA_OP_REGISTER && c_act == NRA_REG_UNREGISTER &&
    is_reg && key_ok |=> !regm_q[$past(c_host)])
    else $error("unregister left host registered");
  unreg_release_a: assert property (
    exec && c_op == NRA_OP_REGISTER && c_act == NRA_REG_UNREGISTER &&
    is_reg && key_ok && resv_v_q && !all_reg(type_q) &&
    holder_q == c_host |=> !resv_v_q)
    else $error("unregister of holder kept reservation");
  acq_busy_a: assert property (
    exec && c_op == NRA_OP_ACQUIRE && c_act == NRA_ACQ_ACQUIRE && is_reg &&
    key_ok && type_ok(c_type) && resv_v_q && !is_holder
    |=> O_CMD_STATUS == NRA_ST_CONFLICT && $stable(holder_q))
    else $error("acquire over another holder accepted");
  rel_type_a: assert property (
    exec && c_op == NRA_OP_RELEASE && c_act == NRA_REL_RELEASE && is_reg &&
    key_ok && is_holder && c_type != type_q
    |=> O_CMD_STATUS == NRA_ST_INVALID && resv_v_q)
    else $error("release with wrong type not invalid");
  rel_nop_a: assert property (
    exec && c_op == NRA_OP_RELEASE && c_act == NRA_REL_RELEASE && is_reg &&
    key_ok && !is_holder |=> $stable(regm_q) && $stable(resv_v_q) &&
    O_CMD_STATUS == NRA_ST_OK && O_REL_NOTE == '0)
    else $error("release by non-holder changed state");
  zero_key_a: assert property (
    exec && c_op == NRA_OP_ACQUIRE && c_act == NRA_ACQ_PREEMPT && is_reg &&
    key_ok && type_ok(c_type) && resv_v_q && !all_reg(type_q) &&
    preempt_key_field_q == '0 && key_q[holder_q] != '0
    |=> O_CMD_STATUS == NRA_ST_INVALID)
    else $error("zero preempt key not invalid");
  self_pre_a: assert property (
    exec && c_op == NRA_OP_ACQUIRE && c_act == NRA_ACQ_PREEMPT && is_reg &&
    key_ok && type_ok(c_type) && resv_v_q && !all_reg(type_q) &&
    holder_q == c_host && preempt_key_field_q == key_q[c_host]
    |=> regm_q[$past(c_host)] && type_q == $past(c_type))
    else $error("self preempt lost registration or type");
  pre_note_a: assert property (
    exec |=> !O_PRE_NOTE[$past(c_host)] && !O_ABORT_REQ[$past(c_host)])
    else $error("requester notified of own preempt");
  ctrl_keep_a: assert property (
    I_CTRL_RST && !exec && !(wr && key_sel) |=> $stable(regm_q) &&
    $stable(resv_v_q) && $stable(type_q))
    else $error("controller reset touched reservation state");

  acquire_c: cover property (exec && c_op == NRA_OP_ACQUIRE ##1
    O_CMD_STATUS == NRA_ST_OK && resv_v_q);
  preempt_abort_c: cover property (O_ABORT_REQ != '0);
  release_note_c: cover property (O_REL_NOTE != '0);
  unreg_c: cover property (exec && c_op == NRA_OP_REGISTER ##1 !resv_v_q);
endmodule // nra_arbiter

// [shared/nra_pkg.sv]
// Constants for the namespace reservation arbiter
package nra_pkg;
  localparam int NRA_HOSTS = 8;
  localparam int NRA_HID_W = 3;
  localparam int NRA_KEY_W = 32;
  // APB byte offsets
  localparam logic [7:0] NRA_OFF_CMD = 8'h00;
  localparam logic [7:0] NRA_OFF_CURRENT_KEY_FIELD = 8'h04;
  localparam logic [7:0] NRA_OFF_PREEMPT_KEY_FIELD = 8'h08;
  localparam logic [7:0] NRA_OFF_STATUS = 8'h0c;
  localparam logic [7:0] NRA_OFF_RESV = 8'h10;
  localparam logic [7:0] NRA_OFF_NOTE = 8'h14;
  localparam logic [7:0] NRA_OFF_KEY0 = 8'h40;
  // Command word fields
  localparam int NRA_CMD_OP_LSB = 0;
  localparam int NRA_CMD_ACT_LSB = 2;
  localparam int NRA_CMD_TYPE_LSB = 5;
  localparam int NRA_CMD_IGN_BIT = 8;
  localparam int NRA_CMD_HID_LSB = 9;
  // Reservation view fields
  localparam int NRA_RESV_VALID_BIT = 0;
  localparam int NRA_RESV_TYPE_LSB = 1;
  localparam int NRA_RESV_HOLDER_LSB = 4;
  localparam int NRA_RESV_REGM_LSB = 8;
  // Notification register fields
  localparam int NRA_NOTE_REL_LSB = 0;
  localparam int NRA_NOTE_PRE_LSB = 8;
  localparam int NRA_NOTE_ABT_LSB = 16;
  // Operations
  localparam logic [1:0] NRA_OP_REGISTER = 2'h0;
  localparam logic [1:0] NRA_OP_ACQUIRE = 2'h1;
  localparam logic [1:0] NRA_OP_RELEASE = 2'h2;
  // Action codes
  localparam logic [2:0] NRA_REG_UNREGISTER = 3'h1;
  localparam logic [2:0] NRA_ACQ_ACQUIRE = 3'h0;
  localparam logic [2:0] NRA_ACQ_PREEMPT = 3'h1;
  localparam logic [2:0] NRA_ACQ_PREEMPT_ABORT = 3'h2;
  localparam logic [2:0] NRA_REL_RELEASE = 3'h0;
  // Reservation types
  localparam logic [2:0] NRA_T_WE = 3'h1;
  localparam logic [2:0] NRA_T_EA = 3'h2;
  localparam logic [2:0] NRA_T_WE_RO = 3'h3;
  localparam logic [2:0] NRA_T_EA_RO = 3'h4;
  localparam logic [2:0] NRA_T_WE_AR = 3'h5;
  localparam logic [2:0] NRA_T_EA_AR = 3'h6;
  // Completion status
  localparam logic [1:0] NRA_ST_OK = 2'h0;
  localparam logic [1:0] NRA_ST_CONFLICT = 2'h1;
  localparam logic [1:0] NRA_ST_INVALID = 2'h2;
  // Reset values
  localparam logic [31:0] NRA_RST_WORD = 32'h0000_0000;
endpackage

// [dv/nra_apb_host.sv]
// APB master model standing in for host software
`timescale 1ns/10ps
module nra_apb_host (
  input wire logic i_clk,
  input wire logic [31:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_pslverr,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata,
  output logic o_hung
);
  logic [31:0] rdata;
  logic err;
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0;
    o_hung = 1'b0;
  end
  // Leading idle edge keeps psel from being assigned twice in one step
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_pready !== 1'b1 && n < 64);
    rdata = i_prdata;
    err = i_pslverr;
    o_hung <= (n >= 64);
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    // Released data bus must not keep showing the last value
    o_pwdata <= ~d;
  endtask
endmodule // nra_apb_host

// [dv/tb_top.sv]
// Self-checking bench with a behavioural reservation model
`timescale 1ns/10ps
module tb_top;
  import nra_pkg::*;
  localparam logic [1:0] rg = NRA_OP_REGISTER;
  localparam logic [1:0] aq = NRA_OP_ACQUIRE;
  localparam logic [1:0] rl = NRA_OP_RELEASE;
  localparam logic [31:0] x = 32'h100;
  logic clk, rst, crst, psel, pen, pwr, hung, done, rdy, serr;
  logic [7:0] paddr, rel, pre, abt;
  logic [31:0] pwdata, prdata;
  logic [1:0] st;
  logic [31:0] key [8];
  logic [7:0] regm;
  logic rv;
  logic [2:0] rt, rh;
  logic [23:0] sticky;
  int n_mismatch, comparisons;

  nra_arbiter u_nra_arbiter (.I_CLK(clk), .I_RST(rst), .I_CTRL_RST(crst),
    .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(rdy),
    .O_PSLVERR(serr), .O_CMD_DONE(done), .O_CMD_STATUS(st),
    .O_REL_NOTE(rel), .O_PRE_NOTE(pre), .O_ABORT_REQ(abt));
  nra_apb_host u_nra_apb_host (.i_clk(clk), .i_prdata(prdata),
    .i_pready(rdy), .i_pslverr(serr), .o_psel(psel), .o_penable(pen),
    .o_pwrite(pwr), .o_paddr(paddr), .o_pwdata(pwdata), .o_hung(hung));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic complete_run();
    if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk) begin
    if (hung === 1'b1) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_nra_apb_host.xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    u_nra_apb_host.xfer(1'b0, a, 32'h0);
    d = u_nra_apb_host.rdata;
  endtask

  function automatic logic isar(input logic [2:0] t);
    return t == NRA_T_WE_AR || t == NRA_T_EA_AR;
  endfunction

  // Distinct nonzero keys: host index plus one sits in the low nibble
  task automatic reg_host(input int i);
    key[i] = ($urandom & 32'hffff_fff0) | (i + 1);
    wr(8'(NRA_OFF_KEY0 + 4 * i), key[i]);
    regm[i] = 1'b1;
  endtask

  task automatic cmd(input logic [1:0] op, input logic [2:0] act,
                     input logic [2:0] ty, input int ign, input int h,
                     input logic [31:0] crk, input logic [31:0] prk);
    logic [1:0] es;
    logic [7:0] er, ep, ea, drop, me;
    logic hold, ok, take;
    logic [31:0] d, m;
    me = 8'h1 << h;
    es = NRA_ST_OK;
    er = 8'h0;
    ep = 8'h0;
    drop = 8'h0;
    hold = rv && (isar(rt) ? regm[h] : rh == 3'(h));
    ok = regm[h] && (ign != 0 || key[h] == crk);
    take = rv && (isar(rt) ? prk == 0 : prk == key[rh]);
    if (!ok) es = NRA_ST_CONFLICT;
    else if (op == rg ? act != NRA_REG_UNREGISTER :
             op == rl ? act != NRA_REL_RELEASE :
             act > NRA_ACQ_PREEMPT_ABORT || ty < NRA_T_WE || ty > NRA_T_EA_AR)
      es = NRA_ST_INVALID;
    else if (op == rg) begin
      regm &= ~me;
      if (rv && (isar(rt) ? regm == 0 : rh == 3'(h))) begin
        rv = 1'b0;
        if (rt == NRA_T_WE_RO || rt == NRA_T_EA_RO) er = regm;
      end
    end else if (op == rl) begin
      if (hold && ty != rt) es = NRA_ST_INVALID;
      else if (hold) begin
        rv = 1'b0;
        if (rt > NRA_T_EA) er = regm & ~me;
      end
    end else if (act == NRA_ACQ_ACQUIRE) begin
      if (!rv) begin
        rv = 1'b1;
        rt = ty;
        rh = 3'(h);
      end else if (!hold || ty != rt) es = NRA_ST_CONFLICT;
    end else begin
      for (int i = 0; i < 8; i++) drop[i] = regm[i] && key[i] == prk;
      if (take && !isar(rt)) drop = (rh == 3'(h)) ? 8'h0 : 8'h1 << rh;
      else if (take) drop = regm & ~me;
      else if (rv && !isar(rt) && prk == 0) es = NRA_ST_INVALID;
      else if (rv && isar(rt) && drop == 0) es = NRA_ST_CONFLICT;
      if (es == NRA_ST_OK) begin
        if (take) begin
          if (ty != rt) er = regm & ~drop & ~me;
          rt = ty;
          rh = 3'(h);
        end
        regm &= ~drop;
        ep = drop & ~me;
      end
    end
    ea = (op == aq && act == NRA_ACQ_PREEMPT_ABORT) ? ep : 8'h0;
    wr(NRA_OFF_CURRENT_KEY_FIELD, crk);
    wr(NRA_OFF_PREEMPT_KEY_FIELD, prk);
    wr(NRA_OFF_CMD, {20'h0, 3'(h), 1'(ign), ty, act, op});
    #1;
    chk({31'h0, done}, 32'h1);
    chk({30'h0, st}, {30'h0, es});
    chk({8'h0, rel, pre, abt}, {8'h0, er, ep, ea});
    sticky |= {ea, ep, er};
    rd(NRA_OFF_RESV, d);
    m = !rv ? 32'hff01 : isar(rt) ? 32'hff0f : 32'hff7f;
    chk(d & m, {16'h0, regm, 1'b0, rh, rt, rv} & m);
    rd(NRA_OFF_STATUS, d);
    chk(d, {30'h0, es});
  endtask

  initial begin
    logic [31:0] d;
    rst = 1'b1;
    crst = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    regm = 8'h0;
    rv = 1'b0;
    rt = 3'h0;
    rh = 3'h0;
    sticky = 24'h0;
    d = $urandom(32'h9df2df50);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) reg_host(i);
    rd(8'(NRA_OFF_KEY0 + 8), d);
    chk(d, key[2]);
    cmd(aq, NRA_ACQ_ACQUIRE, NRA_T_WE_RO, 0, 6, 32'h7, 0);
    cmd(aq, NRA_ACQ_ACQUIRE, NRA_T_WE_RO, 0, 0, key[0] ^ x, 0);
    cmd(aq, NRA_ACQ_ACQUIRE, NRA_T_WE_RO, 0, 0, key[0], 0);
    cmd(aq, NRA_ACQ_ACQUIRE, NRA_T_WE_RO, 0, 0, key[0], 0);
    cmd(aq, NRA_ACQ_ACQUIRE, NRA_T_EA_RO, 0, 0, key[0], 0);
    cmd(aq, NRA_ACQ_ACQUIRE, NRA_T_WE_RO, 0, 1, key[1], 0);
    cmd(rl, NRA_REL_RELEASE, NRA_T_WE_RO, 0, 1, key[1], 0);
    cmd(rl, NRA_REL_RELEASE, NRA_T_EA, 0, 0, key[0], 0);
    cmd(rl, NRA_REL_RELEASE, NRA_T_WE_RO, 0, 0, key[0] ^ x, 0);
    cmd(rl, NRA_REL_RELEASE, NRA_T_WE_RO, 1, 0, key[0] ^ x, 0);
    cmd(rl, NRA_REL_RELEASE, NRA_T_WE_RO, 0, 0, key[0], 0);
    cmd(aq, NRA_ACQ_ACQUIRE, NRA_T_WE, 1, 0, 0, 0);
    cmd(rl, NRA_REL_RELEASE, NRA_T_WE, 0, 0, key[0], 0);
    cmd(aq, NRA_ACQ_ACQUIRE, NRA_T_EA_RO, 0, 1, key[1], 0);
    cmd(rg, NRA_REG_UNREGISTER, 3'h0, 0, 1, key[1] ^ x, 0);
    cmd(rg, NRA_REG_UNREGISTER, 3'h0, 1, 1, 0, 0);
    reg_host(1);
    cmd(aq, NRA_ACQ_ACQUIRE, NRA_T_WE, 0, 2, key[2], 0);
    cmd(aq, NRA_ACQ_PREEMPT, NRA_T_EA, 0, 3, key[3], 0);
    cmd(aq, NRA_ACQ_PREEMPT, NRA_T_EA, 1, 6, 0, key[4]);
    cmd(aq, NRA_ACQ_PREEMPT, NRA_T_EA, 0, 3, key[3], key[4]);
    cmd(aq, NRA_ACQ_PREEMPT_ABORT, NRA_T_EA, 0, 3, key[3], key[2]);
    cmd(aq, NRA_ACQ_PREEMPT, NRA_T_WE_RO, 0, 3, key[3], key[3]);
    cmd(rl, NRA_REL_RELEASE, NRA_T_WE_RO, 0, 3, key[3], 0);
    reg_host(2);
    reg_host(4);
    cmd(aq, NRA_ACQ_ACQUIRE, NRA_T_WE_AR, 0, 0, key[0], 0);
    cmd(aq, NRA_ACQ_PREEMPT, NRA_T_WE_AR, 0, 1, key[1], 32'h10);
    cmd(aq, NRA_ACQ_PREEMPT_ABORT, NRA_T_WE_AR, 0, 1, key[1], key[5]);
    cmd(aq, NRA_ACQ_PREEMPT, NRA_T_EA_AR, 0, 1, key[1], 0);
    cmd(rg, NRA_REG_UNREGISTER, 3'h0, 0, 1, key[1], 0);
    reg_host(0);
    reg_host(2);
    cmd(aq, NRA_ACQ_PREEMPT, NRA_T_WE, 0, 0, key[0], key[2]);
    cmd(aq, 3'h3, NRA_T_WE, 0, 0, key[0], 0);
    cmd(aq, NRA_ACQ_ACQUIRE, 3'h7, 0, 0, key[0], 0);
    cmd(aq, NRA_ACQ_ACQUIRE, NRA_T_EA, 0, 0, key[0], 0);
    rd(NRA_OFF_NOTE, d);
    chk(d, {8'h0, sticky});
    wr(NRA_OFF_NOTE, 32'h00ff_ffff);
    rd(NRA_OFF_NOTE, d);
    chk(d, 32'h0);
    // Controller reset must leave the reservation in place
    @(posedge clk);
    crst <= 1'b1;
    @(posedge clk);
    crst <= 1'b0;
    rd(NRA_OFF_RESV, d);
    chk(d & 32'hff7f, {16'h0, regm, 1'b0, rh, rt, rv});
    rd(NRA_OFF_CURRENT_KEY_FIELD, d);
    chk(d, key[0]);
    rd(NRA_OFF_PREEMPT_KEY_FIELD, d);
    chk(d, 32'h0);
    rd(8'h20, d);
    chk({d[30:0], u_nra_apb_host.err}, 32'h1);
    complete_run();
  end
endmodule // tb_top
